// ==== shared/ctedge_pkg.sv ====
/*
 * Constants for the charge-time edge control block: register map, field
 * positions, reset value and source codes.
 * Assumes a 16-bit register port and one clock.
 */
package ctedge_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int          ADDR_W             = 4;
   localparam logic [3:0]  EDGE_CONTROL_TWO   = 4'h0;
   localparam logic [3:0]  EDGE_LIVE_STATUS   = 4'h1;
   localparam logic [15:0] CTRL_RESET         = 16'h0000;
   localparam logic [15:0] CTRL_WRITE_MASK    = 16'hfffc;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int A_MODE_BIT = 15;
   localparam int A_POL_BIT  = 14;
   localparam int A_SEL_HI   = 13;
   localparam int A_SEL_LO   = 10;
   localparam int B_FLAG_BIT = 9;
   localparam int A_FLAG_BIT = 8;
   localparam int B_MODE_BIT = 7;
   localparam int B_POL_BIT  = 6;
   localparam int B_SEL_HI   = 5;
   localparam int B_SEL_LO   = 2;

   // ------------------------------------------------------------------
   // Source codes
   // ------------------------------------------------------------------
   localparam logic [3:0] A_SRC_TIMER_UNIT_ONE = 4'h0;
   localparam logic [3:0] A_SRC_OC1    = 4'h1;
   localparam logic [3:0] A_SRC_PIN2   = 4'h2;
   localparam logic [3:0] A_SRC_PIN1   = 4'h3;
   localparam logic [3:0] B_SRC_IC1    = 4'h0;
   localparam logic [3:0] B_SRC_OC1    = 4'h1;
   localparam logic [3:0] B_SRC_PIN1   = 4'h2;
   localparam logic [3:0] B_SRC_PIN2   = 4'h3;
   localparam logic [3:0] B_SRC_COMPARATOR_UNIT_ONE   = 4'h4;

endpackage : ctedge_pkg

// ==== verilog/ctedge_src_mux.sv ====
/*
 * Source selector for one edge channel: picks one of five inputs by code.
 * Assumes codes map to inputs 0..4; other codes give a constant low.
 */
`timescale 1ns/1ps
module ctedge_src_mux
(
   input  wire logic [3:0] sel,
   input  wire logic [4:0] src,
   output logic            picked
);
   // Unknown codes select nothing
   always_comb
   begin
      picked = 1'b0;
      if (sel < 4'h5)
      begin
         picked = src[sel[2:0]];
      end
   end
endmodule : ctedge_src_mux

// ==== verilog/ctedge_qualify.sv ====
/*
 * Edge qualifier for one channel: edge or level mode with polarity.
 * Assumes the source is synchronous to clk.
 */
`timescale 1ns/1ps
module ctedge_qualify
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic src,
   input  wire logic edge_mode,
   input  wire logic pol,
   output logic      hit
);
   logic prev;

   // Previous source sample
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prev <= 1'b0;
      else
         prev <= src;
   end

   // Edge: one matching transition; level: active while at polarity level
   always_comb
   begin
      if (edge_mode)
         hit = pol ? (src & ~prev) : (~src & prev);
      else
         hit = (src == pol);
   end
endmodule : ctedge_qualify

// ==== verilog/ctedge_top.sv ====
/*
 * Edge control for a charge-time measurement unit: two channels with source
 * select, edge/level mode, polarity and sticky occurred flags.
 * Assumes all source inputs and the register port are synchronous to clk.
 */
`timescale 1ns/1ps
module ctedge_top
   import ctedge_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [ctedge_pkg::ADDR_W-1:0] addr,
   input  wire logic [15:0]                   wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output logic      [15:0]                   rdata,
   input  wire logic                          timer_unit_one,
   input  wire logic                          output_compare_unit_one,
   input  wire logic                          input_capture_unit_one,
   input  wire logic                          comparator_unit_one,
   input  wire logic                          external_edge_pin_one,
   input  wire logic                          external_edge_pin_two,
   output logic                               edge_a_active,
   output logic                               edge_b_active
);
   import ctedge_pkg::*;

   // ------------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------------
   logic [15:0] ctrl;
   logic        edge_a_occurred_flag;
   logic        edge_b_occurred_flag;
   logic        hit_a;
   logic        hit_b;
   logic        src_a;
   logic        src_b;
   logic        wr_ctrl;

   assign wr_ctrl = wr && (addr == EDGE_CONTROL_TWO);

   // Configuration fields, flags held apart
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ctrl <= CTRL_RESET;
      else if (wr_ctrl)
         ctrl <= wdata & CTRL_WRITE_MASK;
   end

   // ------------------------------------------------------------------
   // Source select and qualification
   // ------------------------------------------------------------------
   ctedge_src_mux u_mux_a
   (
      .sel    (ctrl[A_SEL_HI:A_SEL_LO]),
      .src    ({1'b0, external_edge_pin_one, external_edge_pin_two,
                output_compare_unit_one, timer_unit_one}),
      .picked (src_a)
   );

   ctedge_src_mux u_mux_b
   (
      .sel    (ctrl[B_SEL_HI:B_SEL_LO]),
      .src    ({comparator_unit_one, external_edge_pin_two, external_edge_pin_one,
                output_compare_unit_one, input_capture_unit_one}),
      .picked (src_b)
   );

   ctedge_qualify u_qual_a
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .src       (src_a),
      .edge_mode (ctrl[A_MODE_BIT]),
      .pol       (ctrl[A_POL_BIT]),
      .hit       (hit_a)
   );

   ctedge_qualify u_qual_b
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .src       (src_b),
      .edge_mode (ctrl[B_MODE_BIT]),
      .pol       (ctrl[B_POL_BIT]),
      .hit       (hit_b)
   );

   // ------------------------------------------------------------------
   // Occurred flags: hardware set wins over software write
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         edge_a_occurred_flag <= 1'b0;
      else if (hit_a)
         edge_a_occurred_flag <= 1'b1;
      else if (wr_ctrl)
         edge_a_occurred_flag <= wdata[A_FLAG_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         edge_b_occurred_flag <= 1'b0;
      else if (hit_b)
         edge_b_occurred_flag <= 1'b1;
      else if (wr_ctrl)
         edge_b_occurred_flag <= wdata[B_FLAG_BIT];
   end

   // Edge state outputs follow the flags
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         edge_a_active <= 1'b0;
         edge_b_active <= 1'b0;
      end
      else
      begin
         edge_a_active <= edge_a_occurred_flag;
         edge_b_active <= edge_b_occurred_flag;
      end
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= 16'h0000;
      else if (rd && addr == EDGE_CONTROL_TWO)
      begin
         rdata                <= ctrl;
         rdata[A_FLAG_BIT]    <= edge_a_occurred_flag;
         rdata[B_FLAG_BIT]    <= edge_b_occurred_flag;
      end
      else if (rd && addr == EDGE_LIVE_STATUS)
         rdata <= {14'h0000, hit_b, hit_a};
      else
         rdata <= 16'h0000;
   end
endmodule : ctedge_top

// ==== dv/ctedge_src_model.sv ====
/* Far-side source levels for the edge bench.
   Assumes new patterns arrive just after a rising edge. */
`timescale 1ns/1ps
module ctedge_src_model
(
   input  wire logic       clk,
   input  wire logic [5:0] pat,
   input  wire logic       slow,
   output logic      [5:0] lvl = 6'h00
);
   int n = 0;
   // Follow the pattern each cycle, or every fourth when slow
   always @(posedge clk)
   begin
      n <= n + 1;
      if (!slow || n % 4 == 0)
         lvl <= pat;
   end
endmodule : ctedge_src_model

// ==== dv/ctedge_asserts.sv ====
/* Port checker for the edge control top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module ctedge_asserts
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        timer_unit_one,
   input wire logic        output_compare_unit_one,
   input wire logic        input_capture_unit_one,
   input wire logic        comparator_unit_one,
   input wire logic        external_edge_pin_one,
   input wire logic        external_edge_pin_two,
   input wire logic        edge_a_active,
   input wire logic        edge_b_active
);
   logic [15:0] sh;
   logic        pa;
   logic        pb;
   wire  [3:0]  va = {external_edge_pin_one, external_edge_pin_two,
                      output_compare_unit_one, timer_unit_one};
   wire  [7:0]  vb = {3'h0, comparator_unit_one, external_edge_pin_two,
                      external_edge_pin_one, output_compare_unit_one, input_capture_unit_one};
   wire         sa = sh[13:12] == 2'h0 && va[sh[11:10]];
   wire         sb = !sh[5] && vb[sh[4:2]];
   // Shadow control word and previous picked samples
   always_ff @(posedge clk)
   begin
      sh <= !rst_n ? 16'h0000 : (wr && addr == 4'h0 ? wdata : sh);
      pa <= rst_n && sa;
      pb <= rst_n && sb;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rdbk; wr && addr == 4'h0 ##1 rd && addr == 4'h0 |=>
      (rdata & 16'hfcff) == ($past(wdata, 2) & 16'hfcfc); endproperty
   a_rdbk: assert property (p_rdbk) else $error("readback");
   property p_unmap; rd && addr > 4'h1 |=> rdata == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_swa; wr && addr == 4'h0 && wdata[8] |-> ##2 edge_a_active; endproperty
   a_swa: assert property (p_swa) else $error("flag a write");
   property p_swb; wr && addr == 4'h0 && wdata[9] |-> ##2 edge_b_active; endproperty
   a_swb: assert property (p_swb) else $error("flag b write");
   property p_lva; !sh[15] && sa == sh[14] |-> ##2 edge_a_active; endproperty
   a_lva: assert property (p_lva) else $error("level a");
   property p_lvb; !sh[7] && sb == sh[6] |-> ##2 edge_b_active; endproperty
   a_lvb: assert property (p_lvb) else $error("level b");
   property p_rsa; sh[15] && sh[14] && sa && !pa |-> ##2 edge_a_active; endproperty
   a_rsa: assert property (p_rsa) else $error("rise a");
   property p_flb; sh[7] && !sh[6] && !sb && pb |-> ##2 edge_b_active; endproperty
   a_flb: assert property (p_flb) else $error("fall b");
endmodule : ctedge_asserts
bind ctedge_top ctedge_asserts chk (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
   .timer_unit_one, .output_compare_unit_one, .input_capture_unit_one, .comparator_unit_one,
   .external_edge_pin_one, .external_edge_pin_two, .edge_a_active, .edge_b_active);

// ==== dv/ctedge_top_test.sv ====
/* Bench: random control words and levels against a cycle model.
   Assumes the source model and checker in dv. */
`timescale 1ns/1ps
`define chk(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module ctedge_top_test;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
   logic [15:0] rdata, d;
   logic [5:0]  pat = 6'h00, lvl;
   logic        act_a, act_b;
   int          n_fail, checked, c, fa, fb, pa, pb, sa, sb, ha, hb, ea, eb, er;
   wire  [3:0]  va = {lvl[4], lvl[5], lvl[1], lvl[0]};
   wire  [7:0]  vb = {3'h0, lvl[3], lvl[5], lvl[4], lvl[1], lvl[2]};
   ctedge_src_model src (.clk, .pat, .slow, .lvl);
   ctedge_top DUT (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .timer_unit_one(lvl[0]),
      .output_compare_unit_one(lvl[1]), .input_capture_unit_one(lvl[2]),
      .comparator_unit_one(lvl[3]), .external_edge_pin_one(lvl[4]),
      .external_edge_pin_two(lvl[5]), .edge_a_active(act_a), .edge_b_active(act_b));
   initial forever #10 clk = ~clk;
   // Cycle model: control word, picked sources and sticky flags
   always @(posedge clk)
   begin
      ea <= fa;
      eb <= fb;
      sa = c[13:12] == 0 && va[c[11:10]];
      sb = !c[5] && vb[c[4:2]];
      ha = c[15] ? (c[14] ? sa && !pa : !sa && pa) : sa == c[14];
      hb = c[7] ? (c[6] ? sb && !pb : !sb && pb) : sb == c[6];
      // Read data: control word with flags, or the live qualified hits
      er <= (rd && addr == 4'h0) ? (c | fb << 9 | fa << 8) :
            (rd && addr == 4'h1) ? (hb << 1 | ha) : 0;
      pa = sa;
      pb = sb;
      fa = (wr && addr == 4'h0) ? wdata[8] | ha : fa | ha;
      fb = (wr && addr == 4'h0) ? wdata[9] | hb : fb | hb;
      c = (wr && addr == 4'h0) ? wdata & 16'hfcfc : c;
      if (!rst_n)
         {c, fa, fb, pa, pb} = 0;
   end
   // Compare outputs with the model every cycle
   always @(negedge clk)
      if (rst_n)
      begin
         `chk(act_a, ea[0])
         `chk(act_b, eb[0])
         `chk(rdata, er[15:0])
      end
   task acc(input logic w, input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= v;
   endtask : acc
   task conclude;
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // Run takes about 1400 cycles; cut off far beyond that
   initial
   begin
      #200000;
      n_fail++;
      conclude();
   end
   // Every source code, random modes, flags cleared and unmapped access
   initial
   begin
      void'($urandom(32'hcdfd1942));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      acc(1'b0, 4'h0, 16'h0000);
      for (int i = 0; i < 80; i++)
      begin
         d = 16'($urandom);
         d[13:10] = 4'(i);
         d[5:2] = 4'(i / 5);
         acc(1'b1, 4'h0, d);
         acc(1'b0, 4'h0, 16'h0000);
         repeat (12)
         begin
            acc(1'b0, 4'($urandom % 2), 16'h0000);
            pat <= 6'($urandom);
            slow <= i[0];
         end
         acc(1'b0, 4'(2 + $urandom % 14), 16'h0000);
         acc(1'b1, 4'(2 + $urandom % 14), 16'($urandom));
         acc(1'b1, 4'h0, d & 16'hfcfc);
      end
      repeat (3) acc(1'b0, 4'h0, 16'h0000);
      conclude();
   end
endmodule : ctedge_top_test
